// ### include/cvsb_params.svh
/*
 * register offsets, field positions, reset values and stream constants
 * of the video capture block.
 * assumes byte addresses on a 32-bit axi4-lite register bus.
 */
`ifndef CVSB_PARAMS_SVH
`define CVSB_PARAMS_SVH
`define CVSB_A_MODE 6'h00
`define CVSB_A_RING 6'h04
`define CVSB_A_SCALE 6'h08
`define CVSB_A_HLIM 6'h0c
`define CVSB_A_VLIM 6'h10
`define CVSB_A_START 6'h14
`define CVSB_A_LIMIT 6'h18
`define CVSB_A_STRIDE 6'h1c
`define CVSB_A_WIN 6'h20
`define CVSB_A_WADDR 6'h24
`define CVSB_A_STAT 6'h28
`define CVSB_A_NEWEST 6'h2c
`define CVSB_B_EN 0
`define CVSB_B_CM_HI 2
`define CVSB_B_CM_LO 1
`define CVSB_B_NOVI 3
`define CVSB_B_FOLLOW 0
`define CVSB_B_YCC 1
`define CVSB_B_MERGE 2
`define CVSB_SCALE_RST 32'h08000800
`define CVSB_UNITY 16'h0800
`define CVSB_LIM_RST 12'hfff
`define CVSB_REDUCE 2'b11
`define CVSB_PREAMBLE 8'hff
`define CVSB_RESP_OK 2'b00
`define CVSB_RESP_ERR 2'b10
`endif

// ### include/cvsb_pkg.sv
/*
 * types shared by the video capture block.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package cvsb_pkg;
    typedef enum logic [0:0] {
        CVSB_WS_IDLE = 1'b0,
        CVSB_WS_BUSY = 1'b1
    } cvsb_ws_t;
    typedef logic [16:0] cvsb_acc_t;
endpackage : cvsb_pkg
`default_nettype wire

// ### src/cvsb_capture.sv
/*
 * video capture back end: ITU-656 stream parser, reduction, ring buffer
 * writer, frame hand-over to the window layer, ycbcr to rgb conversion.
 * assumes one 100 MHz clock, a memory write port with back-pressure and
 * a display controller that pulses disp_frame_start once per frame.
 */
// The register addresses and register access over AXI4-Lite are this design's own decisions.
// Notes on behaviour
// [RULE1] each pixel stored as 16-bit ycbcr word
// [RULE2] window ycbcr pixels converted to rgb
// [RULE3] ring buffer; frame shown only when complete
// [RULE4] rate mismatch: frames skipped or repeated
// [RULE5] software sets ring start and limit
// [RULE6] limit equals start plus 64 n stride
// [RULE7] unaligned limit overruns at most one raster
// [RULE8] follow mode shows newest frame, ignores address
// [RULE9] window stride must equal ring stride
// [RULE10] window size equals reduced capture size
// [RULE11] software selects ycbcr window format
// [RULE12] odd-only bit drops even fields
// [RULE13] reduction only when mode field is 11
// [RULE14] independent reduction: lines, pixel pairs
// [RULE15] factors are 5.11 fixed point ratios
// [RULE16] scale register layout, reset 08000800
// [RULE17] pixel limits clamp what reaches scaling
// [RULE18] vertical interpolation unless bit set
// [RULE19] missing control code flags status error
// [RULE20] interlace display uses merged-field settings
// [RULE21] ring sized about 2.2 frames
// [RULE22] capture only while enabled, sampled link clock
// [RULE23] merged mode interleaves odd and even lines
// [RULE24] pointer wraps to start at limit
`include "cvsb_params.svh"
`default_nettype none
module cvsb_capture
    import cvsb_pkg::*;
(
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // video link
    input wire logic capture_clock,
    input wire logic [7:0] video_data,
    // register bus
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // memory write port
    output logic mem_wvalid,
    input wire logic mem_wready,
    output logic [31:0] mem_waddr,
    output logic [15:0] mem_wdata,
    // window layer
    input wire logic disp_frame_start,
    output logic [31:0] win_base_addr,
    input wire logic win_pix_valid,
    input wire logic [7:0] win_y,
    input wire logic [7:0] win_cb,
    input wire logic [7:0] win_cr,
    output logic win_rgb_valid,
    output logic [23:0] win_rgb
);
    function automatic logic [31:0] cvsb_merge(input logic [31:0] o, input logic [31:0] d,
                                               input logic [3:0] s);
        cvsb_merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) cvsb_merge[i*8 +: 8] = d[i*8 +: 8];
        end
    endfunction : cvsb_merge

    function automatic logic cvsb_mapped(input logic [5:0] a);
        cvsb_mapped = (a[1:0] == 2'b00) && (a <= `CVSB_A_NEWEST);
    endfunction : cvsb_mapped

    function automatic logic [15:0] cvsb_fac(input logic [15:0] f, input logic [1:0] cm);
        cvsb_fac = (cm == `CVSB_REDUCE && f >= `CVSB_UNITY) ? f : `CVSB_UNITY; // RULE15
    endfunction : cvsb_fac

    // returns {keep, next accumulator}: one output per fac/unity inputs
    function automatic logic [17:0] cvsb_step(input cvsb_acc_t acc, input logic [15:0] fac);
        cvsb_acc_t sum;
        sum = acc + 17'(`CVSB_UNITY);
        if (sum >= {1'b0, fac}) cvsb_step = {1'b1, sum - {1'b0, fac}};
        else cvsb_step = {1'b0, sum};
    endfunction : cvsb_step

    function automatic logic [31:0] cvsb_wrap(input logic [31:0] a, input logic [31:0] lim,
                                              input logic [31:0] st);
        cvsb_wrap = (a >= lim) ? st : a;
    endfunction : cvsb_wrap

    function automatic logic [7:0] cvsb_clip(input logic signed [19:0] v);
        if (v < 0) cvsb_clip = 8'h00;
        else if (v[19:16] != 4'h0) cvsb_clip = 8'hff;
        else cvsb_clip = v[15:8];
    endfunction : cvsb_clip

    logic [3:0] capture_mode_register;
    logic odd_field_only;
    logic [31:0] capture_scale_factors;
    logic [11:0] horizontal_pixel_limit;
    logic [11:0] vertical_pixel_limit;
    logic [31:0] ring_start_address;
    logic [31:0] ring_limit_address;
    logic [15:0] ring_stride;
    logic [2:0] window_mode;
    logic [31:0] window_normal_address;
    logic [3:0] capture_status;
    logic [31:0] newest;
    logic aw_got, w_got;
    logic [5:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic [31:0] rd_word;

    wire logic capture_enable_bit = capture_mode_register[`CVSB_B_EN];
    wire logic [1:0] capture_mode_field =
        capture_mode_register[`CVSB_B_CM_HI:`CVSB_B_CM_LO];
    wire logic no_vertical_interp = capture_mode_register[`CVSB_B_NOVI];
    wire logic window_follow_capture = window_mode[`CVSB_B_FOLLOW];
    wire logic window_luma_chroma_format = window_mode[`CVSB_B_YCC];
    wire logic window_merge_select = window_mode[`CVSB_B_MERGE];
    wire logic [15:0] vfac = cvsb_fac(capture_scale_factors[31:16], capture_mode_field); // RULE13
    wire logic [15:0] hfac = cvsb_fac(capture_scale_factors[15:0], capture_mode_field); // RULE13
    wire logic [31:0] rowb = {10'h000, ring_stride, 6'h00};
    wire logic interp = !no_vertical_interp; // RULE18
    wire logic merged_field_mode = no_vertical_interp && window_merge_select;
    wire logic wr_do = aw_got && w_got && !s_axi_bvalid;

    // register bus: address and data taken in either order
    assign s_axi_awready = !aw_got;
    assign s_axi_wready = !w_got;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_a <= 6'h00;
            w_d <= 32'h0;
            w_s <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CVSB_RESP_OK;
        end else begin
            if (s_axi_awvalid && !aw_got) begin
                aw_got <= 1'b1;
                aw_a <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got) begin
                w_got <= 1'b1;
                w_d <= s_axi_wdata;
                w_s <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= cvsb_mapped(aw_a) ? `CVSB_RESP_OK : `CVSB_RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_mode_register <= 4'h0;
            odd_field_only <= 1'b0;
            capture_scale_factors <= `CVSB_SCALE_RST; // RULE16
            horizontal_pixel_limit <= `CVSB_LIM_RST;
            vertical_pixel_limit <= `CVSB_LIM_RST;
            ring_start_address <= 32'h0;
            ring_limit_address <= 32'h0;
            ring_stride <= 16'h0;
            window_mode <= 3'h0;
            window_normal_address <= 32'h0;
        end else if (wr_do) begin
            case (aw_a)
                `CVSB_A_MODE: capture_mode_register <=
                    4'(cvsb_merge({28'h0, capture_mode_register}, w_d, w_s));
                `CVSB_A_RING: odd_field_only <= 1'(cvsb_merge({31'h0, odd_field_only}, w_d, w_s));
                `CVSB_A_SCALE: capture_scale_factors <=
                    cvsb_merge(capture_scale_factors, w_d, w_s); // RULE16
                `CVSB_A_HLIM: horizontal_pixel_limit <=
                    12'(cvsb_merge({20'h0, horizontal_pixel_limit}, w_d, w_s));
                `CVSB_A_VLIM: vertical_pixel_limit <=
                    12'(cvsb_merge({20'h0, vertical_pixel_limit}, w_d, w_s));
                `CVSB_A_START: ring_start_address <= cvsb_merge(ring_start_address, w_d, w_s);
                `CVSB_A_LIMIT: ring_limit_address <= cvsb_merge(ring_limit_address, w_d, w_s);
                `CVSB_A_STRIDE: ring_stride <= 16'(cvsb_merge({16'h0, ring_stride}, w_d, w_s));
                `CVSB_A_WIN: window_mode <= 3'(cvsb_merge({29'h0, window_mode}, w_d, w_s));
                `CVSB_A_WADDR: window_normal_address <=
                    cvsb_merge(window_normal_address, w_d, w_s);
                default: ;
            endcase
        end
    end

    always_comb begin
        case (s_axi_araddr)
            `CVSB_A_MODE: rd_word = {28'h0, capture_mode_register};
            `CVSB_A_RING: rd_word = {31'h0, odd_field_only};
            `CVSB_A_SCALE: rd_word = capture_scale_factors;
            `CVSB_A_HLIM: rd_word = {20'h0, horizontal_pixel_limit};
            `CVSB_A_VLIM: rd_word = {20'h0, vertical_pixel_limit};
            `CVSB_A_START: rd_word = ring_start_address;
            `CVSB_A_LIMIT: rd_word = ring_limit_address;
            `CVSB_A_STRIDE: rd_word = {16'h0, ring_stride};
            `CVSB_A_WIN: rd_word = {29'h0, window_mode};
            `CVSB_A_WADDR: rd_word = window_normal_address;
            `CVSB_A_STAT: rd_word = {28'h0, capture_status};
            `CVSB_A_NEWEST: rd_word = newest;
            default: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `CVSB_RESP_OK;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= cvsb_mapped(s_axi_araddr) ? `CVSB_RESP_OK : `CVSB_RESP_ERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // link sampling; data taken on the falling edge, mid-way in its valid time
    logic [2:0] capture_clock_s;
    logic [7:0] d_s1, d_s2;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_clock_s <= 3'h0;
            d_s1 <= 8'h00;
            d_s2 <= 8'h00;
        end else begin
            capture_clock_s <= {capture_clock_s[1:0], capture_clock}; // RULE22
            d_s1 <= video_data;
            d_s2 <= d_s1;
        end
    end

    logic [1:0] code_cnt;
    logic vb, line_open, fld_act, lkeep;
    logic [1:0] phase;
    wire logic take = capture_clock_s[2] && !capture_clock_s[1];
    wire logic in_code = take && code_cnt != 2'd0;
    wire logic xy_take = in_code && code_cnt == 2'd1;
    wire logic xf = d_s2[6];
    wire logic xv = d_s2[5];
    wire logic xh = d_s2[4];
    wire logic prot_ok = d_s2[3:0] == {xv ^ xh, xf ^ xh, xf ^ xv, xf ^ xv ^ xh};
    wire logic xy_ok = xy_take && prot_ok;
    wire logic bad_pre = in_code && code_cnt != 2'd1 && d_s2 != 8'h00;
    wire logic bad_prot = xy_take && !prot_ok;
    wire logic sav = xy_ok && !xh && !xv;
    wire logic eav = xy_ok && xh && !xv;
    wire logic fend = xy_ok && xv && !vb;
    wire logic seq_err = (sav && line_open) || (eav && !line_open);
    wire logic vid = take && code_cnt == 2'd0 && d_s2 != `CVSB_PREAMBLE && line_open && lkeep;

    // stream framing: preamble, sav/eav, vertical blanking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_cnt <= 2'd0;
            vb <= 1'b1;
            line_open <= 1'b0;
        end else begin
            if (take && code_cnt == 2'd0 && d_s2 == `CVSB_PREAMBLE) code_cnt <= 2'd3;
            else if (in_code) code_cnt <= code_cnt - 2'd1;
            if (xy_ok) vb <= xv;
            if (sav) line_open <= 1'b1;
            else if (eav) line_open <= 1'b0;
        end
    end

    // field and line pointers in the ring
    cvsb_acc_t vacc;
    logic [11:0] lcnt;
    logic [31:0] row1, frame_base;
    wire logic [17:0] vs = cvsb_step(vacc, vfac);
    wire logic fr_done = fend && fld_act && (!merged_field_mode || xf || odd_field_only);
    wire logic [31:0] base_n = fr_done ? row1 : frame_base;
    wire logic [31:0] rstep = (interp || merged_field_mode) ? {rowb[30:0], 1'b0} : rowb;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fld_act <= 1'b0;
            lkeep <= 1'b0;
            vacc <= 17'h0;
            lcnt <= 12'h0;
            row1 <= 32'h0;
            frame_base <= 32'h0;
            newest <= 32'h0;
        end else if (!capture_enable_bit) begin
            fld_act <= 1'b0; // RULE22
            lkeep <= 1'b0; // RULE22
            row1 <= ring_start_address;
            frame_base <= ring_start_address;
        end else if (fend) begin
            if (fr_done) newest <= frame_base; // RULE3
            frame_base <= base_n;
            // next field is the even one when this one was odd
            row1 <= (merged_field_mode && !xf && !odd_field_only) ?
                cvsb_wrap(base_n + rowb, ring_limit_address, ring_start_address) : base_n; // RULE23
            fld_act <= !(odd_field_only && !xf); // RULE12
            vacc <= 17'h0;
            lcnt <= 12'h0;
        end else if (sav) begin
            vacc <= vs[16:0]; // RULE14
            lkeep <= fld_act && vs[17] && lcnt < vertical_pixel_limit; // RULE17
            lcnt <= lcnt + 12'h1;
        end else if (eav && lkeep) begin
            lkeep <= 1'b0;
            row1 <= cvsb_wrap(row1 + rstep, ring_limit_address, ring_start_address); // RULE24 RULE7
        end
    end

    // pixel pairs: cb y0 cr y1, reduced in pair units
    cvsb_acc_t hacc;
    logic [11:0] hcnt;
    logic [10:0] col;
    logic [7:0] cb_r, y0_r, cr_r;
    wire logic [17:0] hs = cvsb_step(hacc, hfac);
    wire logic push = vid && phase == 2'd3 && hs[17] && hcnt < horizontal_pixel_limit; // RULE17
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 2'd0;
            hacc <= 17'h0;
            hcnt <= 12'h0;
            col <= 11'h0;
            cb_r <= 8'h00;
            y0_r <= 8'h00;
            cr_r <= 8'h00;
        end else if (sav) begin
            phase <= 2'd0;
            hacc <= 17'h0;
            hcnt <= 12'h0;
            col <= 11'h0;
        end else if (vid) begin
            phase <= phase + 2'd1;
            if (phase == 2'd0) cb_r <= d_s2;
            if (phase == 2'd1) y0_r <= d_s2;
            if (phase == 2'd2) cr_r <= d_s2;
            if (phase == 2'd3) begin
                hacc <= hs[16:0]; // RULE14
                hcnt <= hcnt + 12'h2;
                if (push) col <= col + 11'h1;
            end
        end
    end

    // memory writer: two words per pair, four when lines are doubled
    cvsb_ws_t ws;
    logic [1:0] wk;
    logic [31:0] pa, pb;
    logic [15:0] p0, p1;
    wire logic [31:0] coff = {19'h0, col, 2'b00};
    wire logic [1:0] wlast = interp ? 2'd3 : 2'd1;
    wire logic overrun = push && ws == CVSB_WS_BUSY;
    assign mem_wvalid = ws == CVSB_WS_BUSY;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ws <= CVSB_WS_IDLE;
            wk <= 2'd0;
            pa <= 32'h0;
            pb <= 32'h0;
            p0 <= 16'h0;
            p1 <= 16'h0;
            mem_waddr <= 32'h0;
            mem_wdata <= 16'h0;
        end else begin
            case (ws)
                CVSB_WS_IDLE: begin
                    if (push) begin
                        ws <= CVSB_WS_BUSY;
                        wk <= 2'd0;
                        pa <= row1 + coff;
                        pb <= cvsb_wrap(row1 + rowb, ring_limit_address,
                                        ring_start_address) + coff; // RULE18
                        mem_waddr <= row1 + coff;
                        mem_wdata <= {y0_r, cb_r}; // RULE1
                        p0 <= {y0_r, cb_r}; // RULE1
                        p1 <= {d_s2, cr_r}; // RULE1
                    end
                end
                CVSB_WS_BUSY: begin
                    if (mem_wready) begin
                        if (wk == wlast) begin
                            ws <= CVSB_WS_IDLE;
                        end else begin
                            wk <= wk + 2'd1;
                            mem_waddr <= (wk == 2'd1 ? pb : (wk == 2'd0 ? pa : pb)) +
                                         (wk == 2'd1 ? 32'h0 : 32'h2);
                            // pair kept apart: the next pair may load cb_r/y0_r meanwhile
                            mem_wdata <= (wk == 2'd1) ? p0 : p1;
                        end
                    end
                end
                default: ws <= CVSB_WS_IDLE;
            endcase
        end
    end

    // error flags: write one to clear, a new event wins over the clear
    wire logic [3:0] err_set = {overrun, seq_err, bad_prot, bad_pre};
    always_ff @(posedge aclk) begin
        if (!aresetn) capture_status <= 4'h0;
        else if (wr_do && aw_a == `CVSB_A_STAT && w_s[0])
            capture_status <= (capture_status & ~w_d[3:0]) | err_set; // RULE19
        else capture_status <= capture_status | err_set; // RULE19
    end

    // window layer: frame chosen once per display frame
    always_ff @(posedge aclk) begin
        if (!aresetn) win_base_addr <= 32'h0;
        else if (disp_frame_start)
            win_base_addr <= window_follow_capture ? newest : window_normal_address; // RULE8 RULE4
    end

    logic signed [9:0] cbd, crd;
    logic signed [19:0] rr, gg, bb;
    wire logic signed [19:0] y256 = $signed({4'h0, win_y, 8'h00});
    assign cbd = $signed({2'b00, win_cb}) - 10'sh080;
    assign crd = $signed({2'b00, win_cr}) - 10'sh080;
    assign rr = y256 + 20'sh00167 * crd;
    assign gg = y256 - 20'sh00058 * cbd - 20'sh000b7 * crd;
    assign bb = y256 + 20'sh001c6 * cbd;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_rgb_valid <= 1'b0;
            win_rgb <= 24'h0;
        end else begin
            win_rgb_valid <= win_pix_valid;
            if (win_pix_valid)
                win_rgb <= window_luma_chroma_format ?
                    {cvsb_clip(rr), cvsb_clip(gg), cvsb_clip(bb)} : {win_y, win_cb, win_cr}; // RULE2
        end
    end

    default clocking cb_a @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_frame_pick;
        disp_frame_start && window_follow_capture;
    endsequence
    sequence s_odd_end;
        fend && capture_enable_bit && odd_field_only && !xf;
    endsequence
    property p_scale_rst; // RULE16
        $rose(aresetn) |-> capture_scale_factors == `CVSB_SCALE_RST;
    endproperty
    a_scale_rst: assert property (p_scale_rst) else $error("scale reset wrong"); // RULE16
    property p_gate; // RULE13
        capture_mode_field != `CVSB_REDUCE |-> hfac == `CVSB_UNITY && vfac == `CVSB_UNITY;
    endproperty
    a_gate: assert property (p_gate) else $error("reduction without mode 11"); // RULE13
    property p_bound; // RULE7
        mem_wvalid && ring_limit_address > ring_start_address && !$changed(ring_stride)
            |-> mem_waddr < ring_limit_address + rowb + rowb;
    endproperty
    a_bound: assert property (p_bound) else $error("write beyond limit"); // RULE7
    property p_hold; // RULE3
        !fr_done |=> $stable(newest);
    endproperty
    a_hold: assert property (p_hold) else $error("newest moved mid frame"); // RULE3
    property p_follow; // RULE8
        s_frame_pick |=> win_base_addr == $past(newest);
    endproperty
    a_follow: assert property (p_follow) else $error("window not on newest"); // RULE8
    property p_err; // RULE19
        bad_pre || bad_prot |=> (capture_status[1:0] != 2'b00) [*2];
    endproperty
    a_err: assert property (p_err) else $error("code error not flagged"); // RULE19
    property p_odd; // RULE12
        s_odd_end |=> !fld_act ##1 !lkeep;
    endproperty
    a_odd: assert property (p_odd) else $error("even field captured"); // RULE12
    property p_rgb; // RULE2
        win_pix_valid && window_luma_chroma_format && win_cb == 8'h80 && win_cr == 8'h80
            |=> win_rgb_valid && win_rgb == {3{$past(win_y)}};
    endproperty
    a_rgb: assert property (p_rgb) else $error("grey pixel converted wrong"); // RULE2
endmodule : cvsb_capture
`default_nettype wire

// ### verif/cvsb_decoder_model.sv
/* decoder stand-in: drives stream bytes on its own link clock.
   assumes the bench calls send once per byte and quiet after each line and each field end code. */
`default_nettype none
module cvsb_decoder_model (
    // video link
    output logic capture_clock,
    output logic [7:0] video_data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        capture_clock = 1'h0;
        video_data = 8'h00;
    end
    // byte held through the falling edge that takes it
    task automatic send(input logic [7:0] b);
        video_data = b;
        capture_clock = 1'h1;
        #62.5;
        capture_clock = 1'h0;
        #62.5;
    endtask : send
    // clock stands still; stale data must not look valid
    task automatic quiet;
        video_data = ~video_data;
    endtask : quiet
endmodule : cvsb_decoder_model
`default_nettype wire

// ### verif/test_video_capture_buffer_scaler.sv
/* bench of the capture block: registers, line capture, window outputs.
   assumes the decoder model and a memory that stalls every other cycle. */
`default_nettype none
module test_video_capture_buffer_scaler;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 1'h0, aresetn = 1'h0, mem_wready = 1'h0, disp_frame_start = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, win_pix_valid = 1'h0;
    logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mem_waddr, win_base_addr, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] video_data, win_y = 8'h00, win_cb = 8'h00, win_cr = 8'h00;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic capture_clock, mem_wvalid, win_rgb_valid;
    logic [15:0] mem_wdata;
    logic [23:0] win_rgb;
    logic [47:0] seen[$];
    int n_fail = 0, compares = 0;
    cvsb_capture dut (.*);
    cvsb_decoder_model dec (.capture_clock(capture_clock), .video_data(video_data));
    always #5 aclk = ~aclk;
    always @(posedge aclk) mem_wready <= ~mem_wready;
    always @(posedge aclk) if (mem_wvalid && mem_wready) seen.push_back({mem_waddr, mem_wdata});
    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        compares++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask : chk
    // readies sampled mid-cycle: they are combinational and fall at the taking edge
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end while (!tb);
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        logic ta, tb;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge aclk);
            ta = s_axi_arready;
            tb = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'h0;
        end while (!tb);
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask : rd
    task automatic line(input logic [7:0] p);
        logic [7:0] b[12];
        b = '{8'hff, p, 8'h00, 8'h80, 8'h11, 8'h22, 8'h33, 8'h44, 8'hff, 8'h00, 8'h00, 8'h9d};
        foreach (b[i]) dec.send(b[i]);
        dec.quiet();
        @(posedge aclk);
    endtask : line
    // field end code (v rises); capture only starts on a whole field
    task automatic blank;
        logic [7:0] b[4];
        b = '{8'hff, 8'h00, 8'h00, 8'hb6};
        foreach (b[i]) dec.send(b[i]);
        dec.quiet();
        @(posedge aclk);
    endtask : blank
    task automatic show(input logic [31:0] m, input logic [23:0] px, input logic [31:0] eb,
                        input logic [23:0] er);
        wr(6'h20, m);
        disp_frame_start <= 1'h1;
        win_y <= px[23:16];
        win_cb <= px[15:8];
        win_cr <= px[7:0];
        win_pix_valid <= 1'h1;
        @(posedge aclk);
        disp_frame_start <= 1'h0;
        win_pix_valid <= 1'h0;
        @(negedge aclk);
        chk("base", eb, win_base_addr);
        chk("rgb", er, win_rgb);
        chk("rgb valid", 48'h1, win_rgb_valid);
        @(posedge aclk);
    endtask : show
    task automatic t_regs;
        rd(6'h08);
        chk("scale reset", 48'h08000800, d);
        wr(6'h08, 32'h096808e3);
        rd(6'h08);
        chk("scale", 48'h096808e3, d);
        rd(6'h30);
        chk("unmapped resp", 48'h2, r);
    endtask : t_regs
    task automatic t_capture;
        int n;
        wr(6'h14, 32'h00001000);
        wr(6'h18, 32'h00001100);
        wr(6'h1c, 32'h00000001);
        wr(6'h00, 32'h00000009);
        line(8'h00);
        blank();
        line(8'h00);
        chk("words", 48'h2, seen.size());
        chk("word0", 48'h000010002211, seen[0]);
        chk("word1", 48'h000010024433, seen[1]);
        line(8'h01);
        rd(6'h28);
        chk("status", 48'h1, d & 32'h1);
        wr(6'h04, 32'h00000001);
        blank();
        rd(6'h2c);
        chk("newest", 48'h1000, d);
        n = seen.size();
        line(8'h00);
        chk("odd only", n, seen.size());
        wr(6'h00, 32'h00000008);
        line(8'h00);
        chk("disabled", n, seen.size());
    endtask : t_capture
    task automatic t_window;
        wr(6'h24, 32'h00005000);
        show(32'h0, 24'h123456, 32'h5000, 24'h123456);
        show(32'h7, 24'h408080, 32'h1000, 24'h404040);
    endtask : t_window
    task automatic print_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_regs();
        t_capture();
        t_window();
        print_verdict();
    end
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
endmodule : test_video_capture_buffer_scaler
`default_nettype wire
